// >>> core/cotr_fuse_if.sv
// Fuse default path between the loader and the register bank.
// Assumes a single clock domain.
`timescale 1ns/100ps
`default_nettype none
interface cotr_fuse_if;
  import cotr_pkg::*;
  logic load;
  cotr_trim_t dflt [5];
  modport src (output load, output dflt);
  modport dst (input load, input dflt);
endinterface : cotr_fuse_if
`default_nettype wire

// >>> core/cotr_fuse_loader.sv
// Captures fuse defaults once after reset release and pulses a load.
// Assumes fuse outputs are stable while reset is released.
`timescale 1ns/100ps
`default_nettype none
module cotr_fuse_loader
  import cotr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [59:0] fuse_trim_i,
  cotr_fuse_if.src fuse
);
  cotr_state_e state_r, state_nxt;
  cotr_trim_t dflt_r [5];
  cotr_trim_t dflt_nxt [5];

  // Defaults are sampled by the clock, never by the reset itself
  always_comb begin
    state_nxt = state_r;
    dflt_nxt = dflt_r;
    unique case (state_r)
      COTR_LOAD: begin
        for (int i = 0; i < 5; i++) begin
          dflt_nxt[i] = fuse_trim_i[i*12 +: 12];
        end
        state_nxt = COTR_RUN;
      end
      COTR_RUN: begin
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= COTR_LOAD;
      for (int i = 0; i < 5; i++) begin
        dflt_r[i] <= 12'h000;
      end
    end else begin
      state_r <= state_nxt;
      dflt_r <= dflt_nxt;
    end
  end

  // One-cycle load pulse in the capture cycle, right after reset release
  assign fuse.load = (state_r == COTR_LOAD) && !rst_i;
  // Captured slices feed the bank in the load cycle and stay in dflt_r afterwards
  assign fuse.dflt = (state_r == COTR_LOAD) ? dflt_nxt : dflt_r;
endmodule : cotr_fuse_loader
`default_nettype wire

// >>> core/cotr_params.svh
// Constants for the converter offset trim register bank.
// Assumes inclusion by bare name from the cotr_regs module.
`ifndef COTR_PARAMS_SVH
`define COTR_PARAMS_SVH
// Register indices (printed offsets; byte address is four times the index)
`define COTR_IDX_CORE0 12'h330
`define COTR_IDX_CORE1 12'h332
`define COTR_IDX_CORE2A 12'h334
`define COTR_IDX_CORE2B 12'h336
`define COTR_IDX_CORE3C 12'h338
`define COTR_IDX_CORE3D 12'h33A
// Calibration control and status, placed after the trims
`define COTR_IDX_CALCTL 12'h340
`define COTR_IDX_CALSTAT 12'h342
// Field layout
`define COTR_TRIM_MSB 11
`define COTR_RSVD_MSB 15
`define COTR_CTL_OS_BIT 0
`define COTR_CTL_BG_BIT 1
`define COTR_CTL_BGOS_BIT 2
// Reset values
`define COTR_CTL_RESET 3'h0
`define COTR_TRIM_CORE0_RESET 12'h000
`endif

// >>> core/cotr_pkg.sv
// Types shared by the offset trim bank and its fuse loader.
// Assumes cotr_params.svh is on the include path.
package cotr_pkg;
  typedef logic [11:0] cotr_trim_t;
  typedef enum logic [0:0] {COTR_IN_FIRST, COTR_IN_SECOND} cotr_insel_e;
  typedef enum {COTR_LOAD, COTR_RUN} cotr_state_e;
endpackage : cotr_pkg

// >>> core/cotr_regs.sv
// Offset trim register bank for converter cores 0..3 on classic Wishbone.
// Assumes a single 20 MHz clock and fuse values stable at reset release.
// Notes on behaviour
// - Each trim holds 12 unsigned bits applied as its core's offset correction.
// - Spare cores get offset calibration in the foreground step only with offset and background cal on and bg-offset off.
// - Core 2 uses input A trim for input A, input B trim for B.
// - Core 3 uses input C trim for input C, input D trim for D.
// - Trim defaults for 1, 2A, 2B, 3C, 3D load from fuse storage; core 0 loads a constant.
// - Core 1, 2A, 2B, 3C, 3D trims decode at every second index (byte addresses 8 apart).
// - Core 0 trim decodes two indices below core 1, reset value zero.
`timescale 1ns/100ps
`default_nettype none
`include "cotr_params.svh"
module cotr_regs
  import cotr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [59:0] fuse_trim_i,
  input wire logic sample_en_i,
  input wire logic core2_input_sel_i,
  input wire logic core3_input_sel_i,
  input wire logic foreground_cal_done_i,
  input wire logic offset_cal_busy_i,
  output logic [11:0] core_offset_o [4],
  output logic offset_cal_enable_o,
  output logic background_cal_enable_o,
  output logic background_offset_cal_enable_o,
  output logic spare_fg_offset_cal_o
);
  cotr_fuse_if fuse ();
  cotr_trim_t trim_r [6];
  cotr_trim_t trim_nxt [6];
  logic [2:0] ctl_r, ctl_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  cotr_trim_t appl_r [4];
  cotr_trim_t appl_nxt [4];
  logic [11:0] idx;
  logic req;

  // Fuse defaults captured by a separate small loader
  cotr_fuse_loader u_loader (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fuse_trim_i(fuse_trim_i),
    .fuse(fuse)
  );

  // Map a register index to trim slot; 6 means no trim there
  function automatic logic [2:0] trim_slot(input logic [11:0] ix);
    logic [2:0] s;
    s = 3'd6;
    unique case (ix)
      `COTR_IDX_CORE0: s = 3'd0;
      `COTR_IDX_CORE1: s = 3'd1;
      `COTR_IDX_CORE2A: s = 3'd2;
      `COTR_IDX_CORE2B: s = 3'd3;
      `COTR_IDX_CORE3C: s = 3'd4;
      `COTR_IDX_CORE3D: s = 3'd5;
      default: s = 3'd6;
    endcase
    return s;
  endfunction : trim_slot

  // Byte address is four times the printed index
  assign idx = wb_adr_i[13:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;

  // Register file, bus answer and read data
  always_comb begin
    logic [2:0] slot;
    slot = trim_slot(idx);
    trim_nxt = trim_r;
    ctl_nxt = ctl_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    rdat_nxt = rdat_r;
    if (fuse.load) begin
      trim_nxt[0] = `COTR_TRIM_CORE0_RESET;
      for (int i = 0; i < 5; i++) begin
        trim_nxt[i+1] = fuse.dflt[i];
      end
    end else if (req) begin
      rdat_nxt = 32'h0000_0000;
      if (slot != 3'd6) begin
        ack_nxt = 1'b1;
        // Only bits 11:0 are stored, so reserved bits read zero
        rdat_nxt[`COTR_TRIM_MSB:0] = trim_r[slot];
        if (wb_we_i) begin
          if (wb_sel_i[0]) trim_nxt[slot][7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) trim_nxt[slot][11:8] = wb_dat_i[11:8];
        end
      end else if (idx == `COTR_IDX_CALCTL) begin
        ack_nxt = 1'b1;
        rdat_nxt[2:0] = ctl_r;
        if (wb_we_i && wb_sel_i[0]) ctl_nxt = wb_dat_i[2:0];
      end else if (idx == `COTR_IDX_CALSTAT) begin
        ack_nxt = 1'b1;
        rdat_nxt[0] = foreground_cal_done_i;
        rdat_nxt[1] = offset_cal_busy_i;
        // Access advice: trims safe to touch now
        rdat_nxt[2] = trims_open(ctl_r, foreground_cal_done_i, offset_cal_busy_i);
      end else begin
        err_nxt = 1'b1;
      end
    end
  end

  // Advisory access window; the bank never blocks software itself
  function automatic logic trims_open(input logic [2:0] c, input logic done,
                                      input logic busy);
    logic os, bg, bgos, r;
    os = c[`COTR_CTL_OS_BIT];
    bg = c[`COTR_CTL_BG_BIT];
    bgos = c[`COTR_CTL_BGOS_BIT];
    if (busy) r = 1'b0;
    else if (bg && bgos) r = 1'b0;
    else if (os) r = done;
    else r = 1'b1;
    return r;
  endfunction : trims_open

  // Applied corrections update only on a sample strobe
  always_comb begin
    appl_nxt = appl_r;
    if (sample_en_i) begin
      appl_nxt[0] = trim_r[0];
      appl_nxt[1] = trim_r[1];
      appl_nxt[2] = core2_input_sel_i ? trim_r[3] : trim_r[2];
      appl_nxt[3] = core3_input_sel_i ? trim_r[5] : trim_r[4];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 6; i++) begin
        trim_r[i] <= 12'h000;
      end
      for (int i = 0; i < 4; i++) begin
        appl_r[i] <= 12'h000;
      end
      ctl_r <= `COTR_CTL_RESET;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      trim_r <= trim_nxt;
      appl_r <= appl_nxt;
      ctl_r <= ctl_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = rdat_r;
  assign core_offset_o = appl_r;
  assign offset_cal_enable_o = ctl_r[`COTR_CTL_OS_BIT];
  assign background_cal_enable_o = ctl_r[`COTR_CTL_BG_BIT];
  assign background_offset_cal_enable_o = ctl_r[`COTR_CTL_BGOS_BIT];
  // Spare cores join the foreground offset step when offset and background cal are on and bg-offset is off
  assign spare_fg_offset_cal_o = ctl_r[`COTR_CTL_OS_BIT] && ctl_r[`COTR_CTL_BG_BIT]
                                 && !ctl_r[`COTR_CTL_BGOS_BIT];
endmodule : cotr_regs
`default_nettype wire

// >>> test/cotr_regs_props.sv
// Checker for the offset trim bank, fed from the top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module cotr_regs_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic sample_en_i,
  input wire logic [11:0] core_offset_o [4],
  input wire logic offset_cal_enable_o,
  input wire logic background_cal_enable_o,
  input wire logic background_offset_cal_enable_o,
  input wire logic spare_fg_offset_cal_o
);
  logic mapped;
  // Word indices that answer with ack
  assign mapped = wb_adr_i[13:2] inside {12'h0330, 12'h0332, 12'h0334, 12'h0336,
    12'h0338, 12'h033a, 12'h0340, 12'h0342};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Fuse-load edge is excluded, it may defer the answer
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !$past(rst_i);
  endsequence
  a_answer_next: assert property (s_taken |=>
    (wb_ack_o != wb_err_o) && (wb_err_o == !$past(mapped)))
    else $error("bus answer wrong");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_spare_cal: assert property (spare_fg_offset_cal_o == (offset_cal_enable_o
    && background_cal_enable_o && !background_offset_cal_enable_o))
    else $error("spare calibration flag wrong");
  a_offset_hold: assert property (!sample_en_i |=>
    $stable(core_offset_o[2]) && $stable(core_offset_o[3]))
    else $error("offset moved without sample");
  a_ctl_by_write: assert property ($changed({offset_cal_enable_o,
    background_cal_enable_o, background_offset_cal_enable_o})
    |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("enables changed without write");
  a_dat_hold: assert property ($changed(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("read data changed while idle");
endmodule : cotr_regs_props
`default_nettype wire

// >>> test/cotr_regs_tb_top.sv
// Self-checking bench for the offset trim bank.
// Assumes the bank answers one cycle after a taken request.
`timescale 1ns/100ps
`default_nettype none
module cotr_regs_tb_top;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, sample_en_i = 0;
  logic core2_input_sel_i = 0, core3_input_sel_i = 0, foreground_cal_done_i = 1;
  logic offset_cal_busy_i = 0, wb_ack_o, wb_err_o, er, os_o, bg_o, bgos_o, sp_o;
  logic [13:0] wb_adr_i = 14'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic [59:0] fuse_trim_i = 60'h321_6549_87cb_afed;
  logic [11:0] core_offset_o [4];
  int err_total = 0, checks = 0;
  logic [13:0] ta [8] = '{14'h0cc0, 14'h0cc8, 14'h0cd0, 14'h0cd8, 14'h0ce0, 14'h0ce8, 14'h0d00, 14'h0d08};
  // Reserved bits 15:12 always written as zero
  logic [31:0] tw [8] = '{32'h0000_0123, 32'h0000_0456, 32'h0000_0789, 32'h0000_0abc,
    32'h0000_0def, 32'h0000_05a5, 32'h0000_0003, 32'h0000_00ff};
  logic [31:0] te [8] = '{32'h0000_0123, 32'h0000_0456, 32'h0000_0789, 32'h0000_0abc,
    32'h0000_0def, 32'h0000_05a5, 32'h0000_0003, 32'h0000_0005};
  cotr_regs uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .fuse_trim_i, .sample_en_i,
    .core2_input_sel_i, .core3_input_sel_i, .foreground_cal_done_i, .offset_cal_busy_i,
    .core_offset_o, .offset_cal_enable_o(os_o), .background_cal_enable_o(bg_o),
    .background_offset_cal_enable_o(bgos_o), .spare_fg_offset_cal_o(sp_o));
  // 50 ns period
  initial forever #25 clk_i = ~clk_i;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // One classic cycle; holds the request until ack or err is sampled high
  task automatic bus(input logic [13:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(wb_ack_o || wb_err_o) && n < 20);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
    if (n >= 20) begin
      err_total++;
      tally_and_finish();
    end
  endtask : bus
  // Sample instant with the given input selections
  task automatic samp(input logic s2, input logic s3);
    @(posedge clk_i);
    core2_input_sel_i <= s2; core3_input_sel_i <= s3; sample_en_i <= 1;
    @(posedge clk_i);
    sample_en_i <= 0;
    repeat (2) @(posedge clk_i);
  endtask : samp
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    repeat (2) @(posedge clk_i);
    bus(14'h0cc0, 0, 0); chk(rd, 32'h0000_0000);
    bus(14'h0cc8, 0, 0); chk(rd, 32'h0000_0fed);
    bus(14'h0ce8, 0, 0); chk(rd, 32'h0000_0321);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      bus(ta[i], 1, tw[i]);
      bus(ta[i], 0, 0); chk(rd, te[i]);
    end
    chk({29'h0, bgos_o, bg_o, os_o}, 32'h0000_0003);
    chk({31'h0, sp_o}, 32'h0000_0001);
    $display("table done");
    bus(14'h0cc4, 1, 32'h0000_0fff); chk({31'h0, er}, 32'h0000_0001);
    bus(14'h0cc0, 0, 0); chk(rd, 32'h0000_0123);
    samp(1, 0); chk({20'h0, core_offset_o[2]}, 32'h0000_0abc);
    chk({20'h0, core_offset_o[3]}, 32'h0000_0def);
    chk({20'h0, core_offset_o[1]}, 32'h0000_0456);
    chk({20'h0, core_offset_o[0]}, 32'h0000_0123);
    samp(0, 1); chk({20'h0, core_offset_o[2]}, 32'h0000_0789);
    chk({20'h0, core_offset_o[3]}, 32'h0000_05a5);
    $display("apply done");
    offset_cal_busy_i <= 1;
    bus(14'h0d08, 0, 0); chk(rd, 32'h0000_0003);
    offset_cal_busy_i <= 0; foreground_cal_done_i <= 0;
    bus(14'h0d00, 1, 32'h0000_0001);
    bus(14'h0d08, 0, 0); chk(rd, 32'h0000_0000);
    bus(14'h0d00, 1, 32'h0000_0007);
    chk({29'h0, bgos_o, bg_o, os_o}, 32'h0000_0007);
    chk({31'h0, sp_o}, 32'h0000_0000);
    bus(14'h0d08, 0, 0); chk(rd, 32'h0000_0000);
    bus(14'h0d00, 1, 32'h0000_0000);
    chk({29'h0, bgos_o, bg_o, os_o}, 32'h0000_0000);
    bus(14'h0d08, 0, 0); chk(rd, 32'h0000_0004);
    $display("status done");
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    repeat (2) @(posedge clk_i);
    bus(14'h0cd0, 0, 0); chk(rd, 32'h0000_0cba);
    $display("second reset done");
    tally_and_finish();
  end
endmodule : cotr_regs_tb_top
bind cotr_regs cotr_regs_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .sample_en_i, .core_offset_o,
  .offset_cal_enable_o, .background_cal_enable_o, .background_offset_cal_enable_o,
  .spare_fg_offset_cal_o);
`default_nettype wire
